// [pkg/adcseq_pkg.sv]
// Notes on behaviour
// - regulator start-up wait of 16 us before ready is reported
// - regulator-ready status false during start-up, true afterwards
// - control bit routes internal band-gap to the reference pin, only while the internal ref bit is also set
// - protocol power off clears band-gap routing to default
// - routing write while protocol power off raises an exception flag, no change
// - only converter events drive the analogue interrupt, never comparator
// - 10-bit results, source select among 4 pins, temperature, supply monitor
// - configuring never starts conversion; only start or accumulation start does
// - single-shot: one conversion after start, then stop
// - continuous: back-to-back conversions until disable
// - accumulation start ignores single-shot or continuous selection
// - range select: full scale reference or twice reference
// - interrupt on each single or continuous result when enabled
// - accumulate 2, 4, 8 or 16 conversions, present sum, then stop
// - interrupt when accumulated sum available, if enabled
// - disable stops conversion at any moment in any mode
// - busy true during conversion or accumulation, false when complete
// - status shows new unread sample, or final accumulation sample taken
// - conversion takes three sampling intervals plus 13 converter clocks
// - converter clock is peripheral clock divided by 8, 16, 32 or 64
// - result read: single in low 10 bits, sum in low 14 bits
package adcseq_pkg;
  localparam int          CLK_MHZ         = 200;
  localparam int          REG_START_US    = 16;
  localparam int          REG_START_CYC   = REG_START_US * CLK_MHZ;
  localparam int          CONV_EXTRA      = 13;
  localparam logic [11:0] OFS_COMMON      = 12'h000;
  localparam logic [11:0] OFS_CONV        = 12'h004;
  localparam logic [11:0] OFS_CMD         = 12'h008;
  localparam logic [11:0] OFS_STATUS      = 12'h00C;
  localparam logic [11:0] OFS_RESULT      = 12'h010;
  // common: 0 regulator, 1 irq enable, 3:2 sample, 5:4 clkdiv, 6 internal ref, 7 band-gap
  localparam int          B_REG           = 0;
  localparam int          B_IEN           = 1;
  localparam int          B_SMP           = 2;
  localparam int          B_DIV           = 4;
  localparam int          B_INTREF        = 6;
  localparam int          B_BGAP          = 7;
  // conv: 0 continuous, 1 double range, 4:2 source
  localparam int          B_CONT          = 0;
  localparam int          B_RANGE         = 1;
  localparam int          B_SRC           = 2;
  // cmd: 0 start, 1 accumulate start, 3:2 acc count, 4 stop
  localparam int          B_START         = 0;
  localparam int          B_ACC           = 1;
  localparam int          B_ACCN          = 2;
  localparam int          B_STOP          = 4;
  // status: 0 busy, 1 regulator ready, 2 new sample, 3 exception, 4 accumulation done
  localparam logic [31:0] RESET_VAL       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  typedef enum logic [1:0] {
    ADCSQ_IDLE   = 2'b00,
    ADCSQ_CONV   = 2'b01,
    ADCSQ_WAIT   = 2'b10
  } adcsq_state_t;
endpackage

// [rtl/adcseq_core.sv]
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module adcseq_core
  import adcseq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        protocolPower,
  input  wire logic [9:0]  convSample,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             regulatorOn,
  output logic             bandGapRoute,
  output logic             internalRef,
  output logic             doubleRange,
  output logic [2:0]       sourceSelect,
  output logic             convClockEn,
  output logic             sampleStrobe,
  output logic             apIrq,
  output logic             protectionFault
);
  logic [7:0]   common;
  logic [4:0]   convCfg;
  logic [31:0]  awAddr;
  logic [31:0]  wData;
  logic [3:0]   wStrb;
  logic         awHave;
  logic         wHave;
  logic [15:0]  regCnt;
  logic         regReady;
  logic [5:0]   divCnt;
  logic         tick;
  logic [5:0]   periodCnt;
  logic [4:0]   accLeft;
  logic         accMode;
  logic [13:0]  sum;
  logic [15:0]  result;
  logic         busy;
  logic         newSample;
  logic         accDone;
  logic         faultFlag;
  adcsq_state_t state;
  logic         wrFire;
  logic         rdTake;
  logic         cmdWrite;
  logic         startReq;
  logic         accReq;
  logic         stopReq;
  logic [5:0]   divMax;
  logic [5:0]   convLen;
  logic         convEnd;
  logic         lastConv;

  assign wrFire   = awHave && wHave && !s_axi_bvalid;
  assign rdTake   = s_axi_arvalid && s_axi_arready;
  assign cmdWrite = wrFire && awAddr[11:0] == OFS_CMD && wStrb[0];
  assign startReq = cmdWrite && wData[B_START] && regReady;
  assign accReq   = cmdWrite && wData[B_ACC] && regReady;
  assign stopReq  = cmdWrite && wData[B_STOP];
  assign divMax   = 6'(({4'h0, 2'b01} << (3 + common[B_DIV +: 2])) - 1);
  assign convLen  = 6'(3 * ((32'(common[B_SMP +: 2]) + 1) * 2) + CONV_EXTRA);
  assign convEnd  = state == ADCSQ_CONV && tick && periodCnt == convLen - 6'h01;
  assign lastConv = accMode ? accLeft == 5'h01 : !convCfg[B_CONT];

  // write address and data taken in either order
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      awHave        <= 1'b0;
      wHave         <= 1'b0;
      awAddr        <= RESET_VAL;
      wData         <= RESET_VAL;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr[11:0] <= OFS_CMD && awAddr[1:0] == 2'b00) ? RESP_OK : RESP_SLVERR;
        awHave       <= 1'b0;
        wHave        <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // configuration registers; writes never start a conversion
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      common  <= 8'h00;
      convCfg <= 5'h00;
    end else begin
      if (wrFire && wStrb[0] && awAddr[11:0] == OFS_COMMON) begin
        common[6:0] <= wData[6:0];
        if (protocolPower) begin
          common[B_BGAP] <= wData[B_BGAP];
        end
      end
      if (wrFire && wStrb[0] && awAddr[11:0] == OFS_CONV) begin
        convCfg <= wData[4:0];
      end
      if (!protocolPower) begin
        common[B_BGAP] <= 1'b0;
      end
    end
  end

  // exception when routing is touched without protocol power; sticky until reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      faultFlag <= 1'b0;
    end else if (wrFire && wStrb[0] && awAddr[11:0] == OFS_COMMON && !protocolPower
                 && wData[B_BGAP] != common[B_BGAP]) begin
      faultFlag <= 1'b1;
    end
  end

  // regulator start-up timer
  always_ff @(posedge sys_clk) begin
    if (reset || !common[B_REG]) begin
      regCnt   <= 16'h0000;
      regReady <= 1'b0;
    end else if (!regReady) begin
      if (regCnt == 16'(REG_START_CYC - 1)) begin
        regReady <= 1'b1;
      end
      regCnt <= regCnt + 16'h0001;
    end
  end

  // converter clock enable
  always_ff @(posedge sys_clk) begin
    if (reset || state == ADCSQ_IDLE) begin
      divCnt <= 6'h00;
      tick   <= 1'b0;
    end else begin
      tick   <= divCnt == divMax;
      divCnt <= divCnt == divMax ? 6'h00 : divCnt + 6'h01;
    end
  end

  // conversion sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state     <= ADCSQ_IDLE;
      periodCnt <= 6'h00;
      accLeft   <= 5'h00;
      accMode   <= 1'b0;
      sum       <= 14'h0000;
      result    <= 16'h0000;
      busy      <= 1'b0;
      newSample <= 1'b0;
      accDone   <= 1'b0;
      apIrq     <= 1'b0;
    end else begin
      apIrq <= 1'b0;
      if (rdTake && s_axi_araddr[11:0] == OFS_RESULT) begin
        newSample <= 1'b0;
      end
      if (stopReq || !regReady) begin
        state <= ADCSQ_IDLE;
        busy  <= 1'b0;
      end else if (state == ADCSQ_IDLE && (startReq || accReq)) begin
        state     <= ADCSQ_CONV;
        periodCnt <= 6'h00;
        busy      <= 1'b1;
        accMode   <= accReq;
        accLeft   <= 5'(5'h01 << (1 + wData[B_ACCN +: 2]));
        sum       <= 14'h0000;
        accDone   <= 1'b0;
      end else if (state == ADCSQ_CONV && tick) begin
        periodCnt <= periodCnt + 6'h01;
        if (convEnd) begin
          periodCnt <= 6'h00;
          if (accMode) begin
            sum     <= sum + {4'h0, convSample};
            accLeft <= accLeft - 5'h01;
            if (lastConv) begin
              result  <= {2'b00, sum + {4'h0, convSample}};
              accDone <= 1'b1;
              apIrq   <= common[B_IEN];
            end
          end else begin
            result    <= {6'h00, convSample};
            newSample <= 1'b1;
            apIrq     <= common[B_IEN];
          end
          if (lastConv) begin
            state <= ADCSQ_IDLE;
            busy  <= 1'b0;
          end
        end
      end
    end
  end

  // read channel
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RESET_VAL;
      s_axi_rresp   <= RESP_OK;
    end else if (rdTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      unique case (s_axi_araddr[11:0])
        OFS_COMMON: s_axi_rdata <= {24'h0, common};
        OFS_CONV:   s_axi_rdata <= {27'h0, convCfg};
        OFS_CMD:    s_axi_rdata <= RESET_VAL;
        OFS_STATUS: s_axi_rdata <= {27'h0, accDone, faultFlag, newSample, regReady, busy};
        OFS_RESULT: s_axi_rdata <= {16'h0, result};
        default: begin
          s_axi_rdata <= RESET_VAL;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // analogue side controls; outputs all registered
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regulatorOn     <= 1'b0;
      bandGapRoute    <= 1'b0;
      internalRef     <= 1'b0;
      doubleRange     <= 1'b0;
      sourceSelect    <= 3'h0;
      convClockEn     <= 1'b0;
      sampleStrobe    <= 1'b0;
      protectionFault <= 1'b0;
    end else begin
      regulatorOn     <= common[B_REG];
      // routing gated by internal reference as a guard against misuse
      bandGapRoute    <= common[B_BGAP] && common[B_INTREF];
      internalRef     <= common[B_INTREF];
      doubleRange     <= convCfg[B_RANGE];
      sourceSelect    <= convCfg[B_SRC +: 3];
      convClockEn     <= tick;
      sampleStrobe    <= convEnd;
      protectionFault <= faultFlag;
    end
  end

  AST_BUSY_START: assert property (@(posedge sys_clk) disable iff (reset)
    (state == ADCSQ_IDLE && (startReq || accReq) && !stopReq) |=> busy)
    else $error("busy not raised by start");
  AST_NO_START_UNREADY: assert property (@(posedge sys_clk) disable iff (reset)
    !regReady |=> !busy)
    else $error("busy without regulator ready");
  AST_STOP: assert property (@(posedge sys_clk) disable iff (reset)
    stopReq |=> state == ADCSQ_IDLE && !busy)
    else $error("stop did not halt");
  AST_BGAP_PWR: assert property (@(posedge sys_clk) disable iff (reset)
    !protocolPower |=> !common[B_BGAP])
    else $error("routing kept without protocol power");
  AST_FAULT: assert property (@(posedge sys_clk) disable iff (reset)
    (wrFire && wStrb[0] && awAddr[11:0] == OFS_COMMON && !protocolPower && wData[B_BGAP] != common[B_BGAP])
    |=> faultFlag ##1 protectionFault)
    else $error("exception not flagged");
  AST_SINGLE: assert property (@(posedge sys_clk) disable iff (reset)
    (convEnd && !accMode && !convCfg[B_CONT] && !stopReq && regReady) |=> state == ADCSQ_IDLE && !busy)
    else $error("single shot did not stop");
  AST_CONT: assert property (@(posedge sys_clk) disable iff (reset)
    (convEnd && !accMode && convCfg[B_CONT] && !stopReq && regReady) |=> busy && newSample)
    else $error("continuous stopped");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (reset)
    (convEnd && (!accMode || lastConv) && common[B_IEN] && !stopReq && regReady) |=> apIrq ##1 !apIrq)
    else $error("interrupt missing");
  AST_ACC_IRQ: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(accDone) |-> apIrq == common[B_IEN])
    else $error("accumulation interrupt wrong");
  AST_REG_WAIT: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(regReady) |-> $past(regCnt) == 16'(REG_START_CYC - 1))
    else $error("regulator ready early");
  AST_REG_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
    (!regReady && regCnt < 16'(REG_START_CYC - 1)) |=> !regReady)
    else $error("regulator ready before start-up ends");
  AST_REG_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    !common[B_REG] |=> !regReady)
    else $error("regulator ready while switched off");
  AST_ROUTE_EXTREF: assert property (@(posedge sys_clk) disable iff (reset)
    !common[B_INTREF] |=> !bandGapRoute)
    else $error("routing with external reference");
  AST_IRQ_SOURCE: assert property (@(posedge sys_clk) disable iff (reset)
    apIrq |-> $past(convEnd))
    else $error("interrupt without conversion end");
  AST_NO_CFG_START: assert property (@(posedge sys_clk) disable iff (reset)
    (state == ADCSQ_IDLE && !(startReq || accReq)) |=> state == ADCSQ_IDLE)
    else $error("conversion began without start");
  AST_ACC_IGNORE_MODE: assert property (@(posedge sys_clk) disable iff (reset)
    (convEnd && accMode && !lastConv && !stopReq && regReady) |=> state == ADCSQ_CONV && busy)
    else $error("accumulation ended early");
  AST_RANGE_FOLLOW: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> doubleRange == $past(convCfg[B_RANGE]))
    else $error("range select not applied");
  AST_ACC_STOP: assert property (@(posedge sys_clk) disable iff (reset)
    (convEnd && accMode && lastConv && !stopReq && regReady) |=> state == ADCSQ_IDLE && accDone && !busy)
    else $error("accumulation did not stop");
  AST_TICK_GAP: assert property (@(posedge sys_clk) disable iff (reset)
    tick |=> !tick)
    else $error("converter clock too fast");
  AST_RESULT_SINGLE: assert property (@(posedge sys_clk) disable iff (reset)
    (convEnd && !accMode && !stopReq && regReady) |=> result == {6'h00, $past(convSample)})
    else $error("single result wrong");
  AST_FAULT_STICKY: assert property (@(posedge sys_clk) disable iff (reset)
    faultFlag |=> faultFlag)
    else $error("exception flag lost");
endmodule

// [tb/adcseq_macro_model.sv]
`timescale 1ns/1ps
module adcseq_macro_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] sourceSelect,
  output logic      [9:0] convSample
);
  // each source gives its own level, so a wrong input mux shows up in the result
  always_ff @(posedge sys_clk) begin
    convSample <= {sourceSelect, 7'h15};
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  import adcseq_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        protocolPower = 1'b1;
  logic [9:0]  convSample;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        regulatorOn, bandGapRoute, internalRef, doubleRange, convClockEn;
  logic        sampleStrobe, apIrq, protectionFault;
  logic [2:0]  sourceSelect;
  logic [31:0] rd;
  int          n_mismatch = 0, check_count = 0, cyc = 0, irqCount = 0;
  int          lastIrq = 0, irqGap = 0, lastEn = 0, enGap = 0, strobeCount = 0;

  adcseq_core dut_u (.sys_clk, .reset, .protocolPower, .convSample, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .regulatorOn, .bandGapRoute, .internalRef,
    .doubleRange, .sourceSelect, .convClockEn, .sampleStrobe, .apIrq, .protectionFault);
  adcseq_macro_model model_u (.sys_clk, .sourceSelect, .convSample);

  always #2.5 sys_clk = ~sys_clk;

  // pulse spacing is measured here so tests can judge rates without touching the bus
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (apIrq === 1'b1) begin
      irqCount <= irqCount + 1;
      irqGap <= cyc - lastIrq;
      lastIrq <= cyc;
    end
    if (convClockEn === 1'b1) begin
      enGap <= cyc - lastEn;
      lastEn <= cyc;
    end
    if (sampleStrobe === 1'b1) begin
      strobeCount <= strobeCount + 1;
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {20'h00000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    // registered outputs settle before the caller looks at them
    @(negedge sys_clk);
  endtask

  task automatic axi_read(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= {20'h00000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // polls busy so results are only read once completion is seen
  task automatic wait_idle();
    int t;
    t = 0;
    do begin
      axi_read(OFS_STATUS);
      t++;
    end while (rd[0] !== 1'b0 && t < 2000);
    check_val({31'h0, rd[0]}, 32'h0);
  endtask

  task automatic t_reset();
    axi_read(OFS_COMMON);
    check_val(rd, RESET_VAL);
    check_val({31'h0, bandGapRoute}, 32'h0);
    axi_read(12'h020);
    check_val({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_write(OFS_CMD, 32'h1 << B_START);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[0]}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regulator();
    axi_write(OFS_COMMON, (32'h1 << B_REG) | (32'h1 << B_IEN));
    check_val({31'h0, regulatorOn}, 32'h1);
    axi_write(OFS_CMD, 32'h1 << B_START);
    axi_read(OFS_STATUS);
    check_val(rd & 32'h3, 32'h0);
    repeat (REG_START_CYC - 40) @(posedge sys_clk);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[1]}, 32'h0);
    repeat (60) @(posedge sys_clk);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[1]}, 32'h1);
    $display("test regulator done");
  endtask

  task automatic t_single();
    int n0;
    for (int s = 0; s < 6; s++) begin
      axi_write(OFS_CONV, {29'h0, 3'(s)} << B_SRC);
      check_val({29'h0, sourceSelect}, s);
    end
    axi_write(OFS_CONV, (32'h4 << B_SRC) | (32'h1 << B_RANGE));
    check_val({31'h0, doubleRange}, 32'h1);
    n0 = irqCount;
    repeat (400) @(posedge sys_clk);
    check_val(irqCount, n0);
    axi_write(OFS_CMD, 32'h1 << B_START);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[0]}, 32'h1);
    wait_idle();
    check_val(enGap, 8);
    axi_read(OFS_RESULT);
    check_val(rd, 32'h215);
    repeat (400) @(posedge sys_clk);
    check_val(irqCount, n0 + 1);
    $display("test single done");
  endtask

  task automatic t_cont();
    int n0;
    axi_write(OFS_COMMON, (32'h1 << B_REG) | (32'h1 << B_IEN) | (32'h1 << B_SMP) | (32'h1 << B_DIV));
    axi_write(OFS_CONV, (32'h5 << B_SRC) | (32'h1 << B_CONT));
    n0 = irqCount;
    axi_write(OFS_CMD, 32'h1 << B_START);
    for (int t = 0; t < 3000 && irqCount < n0 + 3; t++) @(posedge sys_clk);
    check_val(irqGap, 400);
    check_val(enGap, 16);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[2]}, 32'h1);
    axi_read(OFS_RESULT);
    check_val(rd, 32'h295);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[2]}, 32'h0);
    axi_write(OFS_CMD, 32'h1 << B_STOP);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[0]}, 32'h0);
    n0 = irqCount;
    repeat (800) @(posedge sys_clk);
    check_val(irqCount, n0);
    $display("test continuous done");
  endtask

  task automatic t_accum();
    int n0, s0;
    axi_write(OFS_COMMON, (32'h1 << B_REG) | (32'h1 << B_IEN));
    axi_write(OFS_CONV, (32'h5 << B_SRC) | (32'h1 << B_CONT));
    for (int n = 0; n < 4; n++) begin
      n0 = irqCount;
      s0 = strobeCount;
      axi_write(OFS_CMD, (32'h1 << B_ACC) | ({30'h0, 2'(n)} << B_ACCN));
      wait_idle();
      axi_read(OFS_RESULT);
      check_val(rd, (32'h2 << n) * 32'h295);
      check_val(strobeCount - s0, 32'h2 << n);
      axi_read(OFS_STATUS);
      check_val({31'h0, rd[4]}, 32'h1);
      repeat (400) @(posedge sys_clk);
      check_val(irqCount, n0 + 1);
    end
    axi_write(OFS_CMD, (32'h1 << B_ACC) | (32'h3 << B_ACCN));
    repeat (500) @(posedge sys_clk);
    axi_write(OFS_CMD, 32'h1 << B_STOP);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[0]}, 32'h0);
    $display("test accumulate done");
  endtask

  task automatic t_bandgap();
    axi_write(OFS_COMMON, (32'h1 << B_REG) | (32'h1 << B_INTREF) | (32'h1 << B_BGAP));
    check_val({30'h0, internalRef, bandGapRoute}, 32'h3);
    @(posedge sys_clk);
    protocolPower <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check_val({31'h0, bandGapRoute}, 32'h0);
    axi_read(OFS_COMMON);
    check_val({31'h0, rd[B_BGAP]}, 32'h0);
    axi_write(OFS_COMMON, (32'h1 << B_REG) | (32'h1 << B_INTREF) | (32'h1 << B_BGAP));
    check_val({30'h0, protectionFault, bandGapRoute}, 32'h2);
    axi_read(OFS_STATUS);
    check_val({31'h0, rd[3]}, 32'h1);
    protocolPower <= 1'b1;
    $display("test bandgap done");
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_regulator();
    t_single();
    t_cont();
    t_accum();
    t_bandgap();
    final_report();
  end
endmodule
